/* shared/rie_pkg.sv */
// Constants and types for the return instruction execute block
`default_nettype none
package rie_pkg;

    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int PC_W_DEFAULT = 13;
    localparam int PC_W_MAX = 16;

    // Opcode encodings
    localparam logic [13:0] OPC_RETURN_FROM_INTERRUPT = 14'h0009;
    localparam logic [13:0] OPC_RETURN = 14'h0008;
    localparam logic [13:0] OPC_RETURN_WITH_LITERAL_MASK = 14'h3C00;
    localparam logic [13:0] OPC_RETURN_WITH_LITERAL_VALUE = 14'h3400;
    localparam int LITERAL_LSB = 0;

    // Interrupt control register field
    localparam int GLOBAL_INTERRUPT_ENABLE_BIT = 7;
    localparam logic [7:0] GLOBAL_INTERRUPT_ENABLE_MASK =
        8'h01 << GLOBAL_INTERRUPT_ENABLE_BIT;

    // Status register flag positions
    localparam int STATUS_C_BIT = 0;
    localparam int STATUS_DC_BIT = 1;
    localparam int STATUS_Z_BIT = 2;

    // Timing in instruction cycles
    localparam int RETURN_WORDS = 1;
    localparam int RETURN_CYCLES = 2;
    localparam logic [1:0] CYCLE_COUNT_RESET = 2'h0;

    typedef enum logic [1:0] {
        RIE_KIND_NONE,
        RIE_KIND_FROM_INTERRUPT,
        RIE_KIND_WITH_LITERAL,
        RIE_KIND_RETURN
    } rie_kind_t;

    typedef struct packed {
        rie_kind_t kind;
        logic [DATA_W-1:0] literal;
    } rie_dec_t;

    typedef struct packed {
        logic stackPop;
        logic pcLoad;
        logic wLoad;
        logic globalInterruptEnableSet;
        logic flushFetch;
    } rie_ctl_t;

    localparam rie_ctl_t CTL_IDLE = '{default: 1'b0};

    function automatic rie_dec_t decode(input logic [INSTR_W-1:0] word);
        rie_dec_t d;
        d.kind = RIE_KIND_NONE;
        d.literal = word[LITERAL_LSB +: DATA_W];
        if (word == OPC_RETURN_FROM_INTERRUPT) begin
            d.kind = RIE_KIND_FROM_INTERRUPT;
        end else if (word == OPC_RETURN) begin
            d.kind = RIE_KIND_RETURN;
        end else if ((word & OPC_RETURN_WITH_LITERAL_MASK)
                == OPC_RETURN_WITH_LITERAL_VALUE) begin
            d.kind = RIE_KIND_WITH_LITERAL;
        end
        return d;
    endfunction

endpackage

`default_nettype wire

/* rtl/rie_decode.sv */
// Opcode decoder for the three return instructions
`timescale 1ns/100ps
`default_nettype none

module rie_decode (
    input wire logic [rie_pkg::INSTR_W-1:0] instrWord,
    output var rie_pkg::rie_dec_t decoded,
    output logic isReturnKind
);

    // Bits 9 and 8 ignored for the literal form by the mask
    always_comb begin
        decoded = rie_pkg::decode(instrWord);
        isReturnKind = (decoded.kind != rie_pkg::RIE_KIND_NONE);
    end

endmodule // rie_decode

`default_nettype wire

/* rtl/rie_execute.sv */
// Execute stage for the return, literal return and interrupt return opcodes
//
// Contract
// - Interrupt return pops the stack into the program counter.
// - Interrupt return also sets global interrupt enable, control bit 7.
// - Interrupt return is one word of two cycles, the second a discard.
// - Literal return copies word bits 7..0 to W, bits 9 and 8 ignored.
// - Literal return also pops the stack into the program counter.
// - Literal return is one word and completes in two instruction cycles.
// - Plain return pops the stack into PC, leaving interrupt enable alone.
// - Plain return is one word and takes two instruction cycles.
`timescale 1ns/100ps
`default_nettype none

module rie_execute #(
    parameter int PC_W = rie_pkg::PC_W_DEFAULT
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cycleEn,
    input wire logic instrValid,
    input wire logic [rie_pkg::INSTR_W-1:0] instrWord,
    input wire logic [PC_W-1:0] topOfStack,
    output logic instrReady,
    output logic instrAccepted,
    output logic stackPop,
    output logic pcLoad,
    output logic [PC_W-1:0] pcValue,
    output logic wLoad,
    output logic [rie_pkg::DATA_W-1:0] wValue,
    output logic interruptControlSet,
    output logic [7:0] interruptControlSetMask,
    output logic flushFetch,
    output logic [2:0] statusWriteMask,
    output logic busy
);

    generate
        if (PC_W < 1 || PC_W > rie_pkg::PC_W_MAX) begin : g_bad_pc_w
            $error("rie_execute: PC_W out of range");
        end
        // Two bit cycle counter cannot serve longer returns
        if (rie_pkg::RETURN_CYCLES < 2
                || rie_pkg::RETURN_CYCLES > 3) begin : g_bad_cycles
            $error("rie_execute: return cycle count unsupported");
        end
    endgenerate

    typedef enum logic {
        RIE_ST_EXEC,
        RIE_ST_DISCARD
    } rie_state_t;

    rie_state_t state;
    rie_state_t next_state;
    rie_pkg::rie_dec_t decoded;
    rie_pkg::rie_ctl_t next_ctl;
    logic isReturnKind;
    logic take;
    logic [1:0] cycleCount;
    logic lastCycle;

    rie_decode u_decode (
        .instrWord(instrWord),
        .decoded(decoded),
        .isReturnKind(isReturnKind)
    );

    // Only return opcodes are claimed; others belong to other units
    assign instrReady = (state == RIE_ST_EXEC);
    assign take = cycleEn && instrValid && isReturnKind
        && (state == RIE_ST_EXEC);
    // Last instruction cycle of a return, counted rather than assumed
    assign lastCycle = (state == RIE_ST_DISCARD) && cycleEn
        && (cycleCount == 2'(rie_pkg::RETURN_CYCLES - 1));

    always_comb begin
        next_state = state;
        unique case (state)
            RIE_ST_EXEC: begin
                if (take) begin
                    next_state = RIE_ST_DISCARD;
                end
            end
            RIE_ST_DISCARD: begin
                // Second instruction cycle ends the return
                if (lastCycle) begin
                    next_state = RIE_ST_EXEC;
                end
            end
        endcase
    end

    always_comb begin
        next_ctl = rie_pkg::CTL_IDLE;
        if (take) begin
            // All three forms pop and reload the program counter
            next_ctl.stackPop = 1'b1;
            next_ctl.pcLoad = 1'b1;
            unique case (decoded.kind)
                rie_pkg::RIE_KIND_FROM_INTERRUPT: begin
                    next_ctl.globalInterruptEnableSet = 1'b1;
                end
                rie_pkg::RIE_KIND_WITH_LITERAL: begin
                    next_ctl.wLoad = 1'b1;
                end
                rie_pkg::RIE_KIND_RETURN: begin
                    next_ctl.globalInterruptEnableSet = 1'b0;
                end
                rie_pkg::RIE_KIND_NONE: begin
                    next_ctl.pcLoad = 1'b0;
                    next_ctl.stackPop = 1'b0;
                end
            endcase
        end else if (lastCycle) begin
            // Word fetched during the return is stale; drop it
            next_ctl.flushFetch = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= RIE_ST_EXEC;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            stackPop <= 1'b0;
        end else begin
            stackPop <= next_ctl.stackPop;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pcLoad <= 1'b0;
        end else begin
            pcLoad <= next_ctl.pcLoad;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wLoad <= 1'b0;
        end else begin
            wLoad <= next_ctl.wLoad;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            interruptControlSet <= 1'b0;
        end else begin
            interruptControlSet <= next_ctl.globalInterruptEnableSet;
        end
    end

    // Mask registered with its strobe so both arrive in one cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            interruptControlSetMask <= 8'h00;
        end else if (next_ctl.globalInterruptEnableSet) begin
            interruptControlSetMask <= rie_pkg::GLOBAL_INTERRUPT_ENABLE_MASK;
        end else begin
            interruptControlSetMask <= 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            flushFetch <= 1'b0;
        end else begin
            flushFetch <= next_ctl.flushFetch;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            instrAccepted <= 1'b0;
        end else begin
            instrAccepted <= take;
        end
    end

    // Instruction cycle counter, set to one on acceptance
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cycleCount <= rie_pkg::CYCLE_COUNT_RESET;
        end else if (take) begin
            cycleCount <= 2'h1;
        end else if (state == RIE_ST_DISCARD && cycleEn) begin
            cycleCount <= cycleCount + 2'h1;
        end else if (state == RIE_ST_EXEC) begin
            cycleCount <= rie_pkg::CYCLE_COUNT_RESET;
        end
    end

    // Data outputs held until updated: pcValue by every return, wValue by literal returns only
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pcValue <= '0;
        end else if (take) begin
            pcValue <= topOfStack;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wValue <= 8'h00;
        end else if (take
                && decoded.kind == rie_pkg::RIE_KIND_WITH_LITERAL) begin
            wValue <= decoded.literal;
        end
    end

    assign busy = (state == RIE_ST_DISCARD);
    // Returns never touch arithmetic flags
    assign statusWriteMask = 3'h0;

endmodule // rie_execute

`default_nettype wire

/* testbench/rie_checker.sv */
// Port assertions for the return execute block
`timescale 1ns/100ps
`default_nettype none
module rie_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cycleEn,
    input wire logic instrValid,
    input wire logic [13:0] instrWord,
    input wire logic stackPop,
    input wire logic pcLoad,
    input wire logic wLoad,
    input wire logic interruptControlSet,
    input wire logic [7:0] interruptControlSetMask,
    input wire logic flushFetch,
    input wire logic [2:0] statusWriteMask,
    input wire logic busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_take(w);
        cycleEn && instrValid && !busy && instrWord == w;
    endsequence
    sequence s_flush;
        ##[1:8] flushFetch && !busy;
    endsequence
    a_intr_ret_pop: assert property (s_take(14'h0009) |=>
        stackPop && pcLoad && interruptControlSet)
        else $error("interrupt return");
    a_return_pop_only: assert property (s_take(14'h0008) |=>
        stackPop && !interruptControlSet && !wLoad)
        else $error("plain return");
    a_lit_ret_loads: assert property (cycleEn && instrValid &&
        !busy && (instrWord & 14'h3C00) == 14'h3400 |=> stackPop && wLoad)
        else $error("literal return");
    a_two_cycles: assert property (stackPop |-> s_flush)
        else $error("no discard cycle");
    a_pop_spaced: assert property (stackPop |=> !stackPop [*3])
        else $error("pops too close");
    a_w_with_pop: assert property (wLoad |-> stackPop && pcLoad)
        else $error("literal without pop");
    a_enable_mask: assert property (interruptControlSetMask ==
        (interruptControlSet ? 8'h80 : 8'h00)) else $error("enable mask");
    a_flags_kept: assert property (statusWriteMask == 3'h0)
        else $error("status written");
endmodule // rie_checker
bind rie_execute rie_checker i_chk (.clk, .nrst, .cycleEn, .instrValid,
    .instrWord, .stackPop, .pcLoad, .wLoad, .interruptControlSet,
    .interruptControlSetMask, .flushFetch, .statusWriteMask, .busy);
`default_nettype wire

/* testbench/rie_partner.sv */
// Fetch stage and stack model: cycle enable, popped addresses
`timescale 1ns/100ps
`default_nettype none
module rie_partner (
    input wire logic clk,
    input wire logic nrst,
    input wire logic stackPop,
    output logic cycleEn,
    output logic [12:0] topOfStack
);
    logic [1:0] phase = 2'h0;
    logic [3:0] depth = 4'h0;
    // Instruction cycle of four clocks, moved off the sampling edge
    always @(negedge clk) phase <= nrst ? phase + 2'h1 : 2'h0;
    assign cycleEn = (phase == 2'h3);
    always @(posedge clk) depth <= !nrst ? 4'h0 : depth + 4'(stackPop);
    assign topOfStack = 13'(16'h1234 + 16'(depth) * 16'h0111);
endmodule // rie_partner
`default_nettype wire

/* testbench/tb_return_instruction_execute.sv */
// Self-checking bench for the return execute block
`timescale 1ns/100ps
`default_nettype none
module tb_return_instruction_execute;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic instrValid = 1'b0;
    logic [13:0] instrWord = 14'h0000;
    logic cycleEn, stackPop, pcLoad, wLoad, flushFetch, busy;
    logic interruptControlSet;
    logic instrReady, instrAccepted;
    logic [12:0] topOfStack, pcValue;
    logic [7:0] wValue, interruptControlSetMask;
    logic [2:0] statusWriteMask;
    int error_cnt = 0;
    int checks_done = 0;
    int pops = 0;
    always #5 clk = ~clk;
    rie_partner i_far (.clk, .nrst, .stackPop, .cycleEn, .topOfStack);
    rie_execute #(.PC_W(13)) i_dut (.clk, .nrst, .cycleEn, .instrValid,
        .instrWord, .topOfStack, .instrReady, .instrAccepted, .stackPop,
        .pcLoad, .pcValue, .wLoad, .wValue, .interruptControlSet,
        .interruptControlSetMask, .flushFetch, .statusWriteMask, .busy);
    task automatic chk(input string n, input logic [15:0] e, s);
        checks_done++;
        if (s !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, s);
            error_cnt++;
        end
    endtask
    // Request held through the busy cycle, so refusal is exercised too
    task automatic ret(input logic [13:0] w, input logic lit, global_interrupt_enable);
        int n;
        logic [12:0] ePc;
        ePc = 13'(16'h1234 + 16'(pops) * 16'h0111);
        @(negedge clk);
        instrValid = 1'b1;
        instrWord = w;
        n = 0;
        do begin @(posedge clk); #1; n++; end
        while (stackPop !== 1'b1 && n < 12);
        chk("pcLoad", 16'h0001, {15'h0, pcLoad});
        chk("pcValue", {3'h0, ePc}, {3'h0, pcValue});
        chk("wLoad", {15'h0, lit}, {15'h0, wLoad});
        if (lit) chk("wValue", {8'h0, w[7:0]}, {8'h0, wValue});
        chk("interruptControlSet", {15'h0, global_interrupt_enable},
            {15'h0, interruptControlSet});
        chk("interruptControlSetMask", {8'h0, global_interrupt_enable ? 8'h80 : 8'h00},
            {8'h0, interruptControlSetMask});
        chk("instrAccepted", 16'h0001, {15'h0, instrAccepted});
        chk("busy", 16'h0001, {15'h0, busy});
        chk("instrReady", 16'h0000, {15'h0, instrReady});
        pops++;
        n = 0;
        do begin @(posedge clk); #1; n++; end
        while (flushFetch !== 1'b1 && n < 12);
        chk("discard gap", 16'h0004, 16'(n));
        chk("busy", 16'h0000, {15'h0, busy});
        chk("instrReady", 16'h0001, {15'h0, instrReady});
        @(negedge clk);
        instrValid = 1'b0;
    endtask
    task automatic t_returns();
        ret(14'h0009, 1'b0, 1'b1);
        ret(14'h3655, 1'b1, 1'b0);
        ret(14'h37FF, 1'b1, 1'b0);
        ret(14'h0008, 1'b0, 1'b0);
        chk("wValue held", 16'h00FF, {8'h0, wValue});
        chk("statusMask", 16'h0000, {13'h0, statusWriteMask});
    endtask
    task automatic t_ignored(input logic [13:0] w, input logic v);
        @(negedge clk);
        instrValid = v;
        instrWord = w;
        repeat (8) begin
            @(posedge clk);
            #1 chk("stackPop", 16'h0000, {15'h0, stackPop});
        end
    endtask
    // Mid-run reset: outputs cleared, stack model back to empty
    task automatic t_reset();
        @(negedge clk);
        nrst = 1'b0;
        repeat (3) @(negedge clk);
        chk("pcValue", 16'h0000, {3'h0, pcValue});
        chk("wValue", 16'h0000, {8'h0, wValue});
        chk("busy", 16'h0000, {15'h0, busy});
        chk("instrReady", 16'h0001, {15'h0, instrReady});
        chk("stackPop", 16'h0000, {15'h0, stackPop});
        nrst = 1'b1;
        pops = 0;
        ret(14'h3412, 1'b1, 1'b0);
    endtask
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        t_returns();
        t_ignored(14'h3800, 1'b1);
        t_ignored(14'h0009, 1'b0);
        t_ignored(14'h000A, 1'b1);
        t_reset();
        end_sim();
    end
    // Tests need well under a thousand cycles
    initial begin
        #20000;
        error_cnt++;
        end_sim();
    end
endmodule // tb_return_instruction_execute
`default_nettype wire
